// ### core/lsr_cfg.svh
/*
 * constants for the light sensor upper configuration and interrupt register bank:
 * register offsets, field positions, reset values.
 * assumes an 8-bit register port decoded by the surrounding i2c slave.
 */
//
// Contract
// RULE_01 - The overall gain is formed from the two-bit gain select plus the top-extend and half-step bits, giving 1/2, 1, 4, 16, 64 or 128 times.
// RULE_02 - Gain top-extend sits at bit 4 and gain half-step at bit 2 of the extended gain register, read/write, resetting to 0 and 1.
// RULE_03 - The host uses only the six listed gain combinations, since others have no defined gain.
// RULE_04 - With clear-on-read (bit 7) set, a host read of the status register clears every status flag.
// RULE_05 - The oscillator is stopped while power-on is 0 and always runs with power-on set and sleep-after-interrupt clear.
// RULE_06 - With sleep-after-interrupt set, the oscillator stops once a completed light cycle raises the interrupt through flag and enable.
// RULE_07 - While stopped by sleep-after-interrupt the device acts powered off, yet power-on still reads back as 1.
// RULE_08 - After a sleep-after-interrupt stop the oscillator restarts only when the host clears the pending status flags; power-on or bit 4 low also wakes.
// RULE_09 - Autozero runs before every nth light cycle for a 7-bit interval n, never for 00h, and only before the first cycle for 7Fh.
// RULE_10 - Interrupt-enable bit 7 gates the saturation interrupt and bit 4 the light-threshold interrupt, both resetting to 0.
// RULE_11 - The interrupt output is driven while the light-threshold flag and its enable are both set.
// RULE_12 - The visible-scale register is a read-only factory byte, sign in the top bit and percent change in the low seven bits.
// RULE_13 - Host software multiplies the visible result by one plus the signed percentage, both zero encodings meaning no change.
// RULE_14 - Writing a one to a status flag bit clears it, whatever the clear-on-read setting.
// RULE_15 - The light-threshold flag sets when consecutive out-of-threshold results equal the persistence setting, the count clearing on any in-range result.
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH

`define LSR_ADDR_STATUS     8'h93
`define LSR_ADDR_EXT_GAIN   8'h9f
`define LSR_ADDR_IRQ_SLEEP  8'hab
`define LSR_ADDR_AUTOZERO   8'hd6
`define LSR_ADDR_IRQ_ENABLE 8'hdd
`define LSR_ADDR_VIS_SCALE  8'he6

`define LSR_RST_EXT_GAIN    8'h04
`define LSR_RST_IRQ_SLEEP   8'h4c
`define LSR_RST_AUTOZERO    8'h7f
`define LSR_RST_IRQ_ENABLE  8'h00
`define LSR_VIS_SCALE_DFLT  8'h00

`define LSR_BIT_TOP_EXTEND  4
`define LSR_BIT_HALF_STEP   2
`define LSR_BIT_READ_CLEAR  7
`define LSR_BIT_SLEEP_IRQ   4
`define LSR_BIT_SAT_IEN     7
`define LSR_BIT_THR_IEN     4
`define LSR_BIT_SAT_FLAG    7
`define LSR_BIT_THR_FLAG    4
`define LSR_BIT_CAL_FLAG    3
`define LSR_MASK_INTERVAL   8'h7f
`define LSR_STATUS_MASK     8'h98
`define LSR_INTERVAL_NEVER  7'h00
`define LSR_INTERVAL_FIRST  7'h7f

`endif

// ### core/lsr_pkg.sv
/*
 * types for the light sensor register bank.
 * assumes lsr_cfg.svh is included by the design file.
 */
package lsr_pkg;

   // overall gain, in the six documented settings plus an undefined code
   typedef enum logic [2:0] {
      GAIN_HALF,
      GAIN_X1,
      GAIN_X4,
      GAIN_X16,
      GAIN_X64,
      GAIN_X128,
      GAIN_UNDEF
   } lsr_gain_t;

   // register port request from the i2c slave
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } lsr_req_t;

   // events from the measurement engine
   typedef struct packed {
      logic       cycleStart;
      logic       cycleDone;
      logic       outOfRange;
      logic       saturated;
      logic       calDone;
      logic [3:0] persistence;
   } lsr_evt_t;

   // whole module state
   typedef struct packed {
      logic [7:0] extGain;
      logic [7:0] irqSleep;
      logic [7:0] autozero;
      logic [7:0] irqEnable;
      logic [7:0] status;
      logic [7:0] rdData;
      logic [3:0] persistCount;
      logic [6:0] cycleCount;
      logic       firstDone;
      logic       sleeping;
   } lsr_state_t;

endpackage

// ### core/lsr_config_irq_regs.sv
/*
 * upper configuration and interrupt register bank of an ambient light sensor:
 * extended gain, clear-on-read, sleep-after-interrupt, autozero interval,
 * interrupt enables, read-only visible scale byte, and the status flags they act on.
 * assumes an i2c slave in front delivering one-cycle read/write strobes, and a
 * measurement engine that reports cycle start/finish and threshold results.
 */
`timescale 1ns/1ps
`include "lsr_cfg.svh"

module lsr_config_irq_regs
   import lsr_pkg::*;
#(
   parameter logic [7:0] VIS_SCALE = `LSR_VIS_SCALE_DFLT  // factory trim, arbitrary default
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // register port
   input  wire lsr_req_t   regReq,
   output      logic [7:0] regRdData,
   // measurement engine
   input  wire lsr_evt_t   evt,
   input  wire logic       powerOnBit,
   input  wire logic [1:0] gainSelect,
   // outputs to the front end and pin
   output      lsr_gain_t  overallGain,
   output      logic       oscEnable,
   output      logic       autozeroRun,
   output      logic       irqOut,
   output      logic       irqPinOe
);

   // flags that the status register really holds; the other bits read 0
   localparam logic [7:0] STATUS_MASK = `LSR_STATUS_MASK;

   // registered state and its next value
   lsr_state_t stateReg;
   lsr_state_t stateNext;

   // host strobes decoded against the register offsets
   logic       statusRead;
   logic       statusWrite;
   logic       wrExtGain;
   logic       wrIrqSleep;
   logic       wrAutozero;
   logic       wrIrqEnable;

   // register fields, named once so the logic below reads plainly
   logic       topExtend;
   logic       halfStep;
   logic       readClearEn;
   logic       sleepEn;
   logic       satIrqEn;
   logic       thrIrqEn;
   logic       satFlag;
   logic       thrFlag;
   logic [6:0] interval;

   // results from the measurement engine
   logic       resultValid;
   logic       inRangeResult;
   logic       outRangeResult;
   logic       thrHit;
   logic [3:0] countInc;

   // autozero scheduling
   logic       cycleTick;
   logic       intervalNever;
   logic       intervalFirst;
   logic       azDue;
   logic       cycleWrap;
   logic [6:0] cycleInc;

   // flag updates and the sleep decision
   logic [7:0] setMask;
   logic [7:0] clrMask;
   logic [7:0] statusNext;
   logic       clearedAll;

   // gain decode; every code is listed so no default is needed
   function automatic lsr_gain_t decodeGain(input logic [1:0] sel, input logic top, input logic half);
      logic [3:0] code;
      code = {sel, top, half};
      unique case (code)
         4'h0: decodeGain = GAIN_HALF;
         4'h1: decodeGain = GAIN_X1;
         4'h2: decodeGain = GAIN_UNDEF;  // undefined on the host's side; see RULE_03
         4'h3: decodeGain = GAIN_UNDEF;
         4'h4: decodeGain = GAIN_UNDEF;
         4'h5: decodeGain = GAIN_X4;
         4'h6: decodeGain = GAIN_UNDEF;
         4'h7: decodeGain = GAIN_UNDEF;
         4'h8: decodeGain = GAIN_UNDEF;
         4'h9: decodeGain = GAIN_X16;
         4'ha: decodeGain = GAIN_UNDEF;
         4'hb: decodeGain = GAIN_UNDEF;
         4'hc: decodeGain = GAIN_UNDEF;
         4'hd: decodeGain = GAIN_X64;
         4'he: decodeGain = GAIN_UNDEF;
         4'hf: decodeGain = GAIN_X128;
      endcase
   endfunction

   // offset decode shared by every read and write strobe
   function automatic logic hitsReg(input logic strobe, input logic [7:0] addr, input logic [7:0] offset);
      hitsReg = strobe && (addr == offset);
   endfunction

   // read multiplexer; unmapped offsets read 00h
   function automatic logic [7:0] readMux(input lsr_state_t s, input logic [7:0] offset);
      unique case (offset)
         `LSR_ADDR_STATUS:     readMux = s.status;
         `LSR_ADDR_EXT_GAIN:   readMux = s.extGain;
         `LSR_ADDR_IRQ_SLEEP:  readMux = s.irqSleep;
         `LSR_ADDR_AUTOZERO:   readMux = s.autozero;
         `LSR_ADDR_IRQ_ENABLE: readMux = s.irqEnable;
         `LSR_ADDR_VIS_SCALE:  readMux = VIS_SCALE;  // see RULE_12
         default:              readMux = 8'h00;
      endcase
   endfunction

   // status strobes
   assign statusRead  = hitsReg(regReq.rdEn, regReq.addr, `LSR_ADDR_STATUS);
   assign statusWrite = hitsReg(regReq.wrEn, regReq.addr, `LSR_ADDR_STATUS);

   // write strobes; the scale byte has none, so writes to it are dropped
   assign wrExtGain   = hitsReg(regReq.wrEn, regReq.addr, `LSR_ADDR_EXT_GAIN);
   assign wrIrqSleep  = hitsReg(regReq.wrEn, regReq.addr, `LSR_ADDR_IRQ_SLEEP);
   assign wrAutozero  = hitsReg(regReq.wrEn, regReq.addr, `LSR_ADDR_AUTOZERO);
   assign wrIrqEnable = hitsReg(regReq.wrEn, regReq.addr, `LSR_ADDR_IRQ_ENABLE);

   // gain fields
   assign topExtend = stateReg.extGain[`LSR_BIT_TOP_EXTEND];  // see RULE_02
   assign halfStep  = stateReg.extGain[`LSR_BIT_HALF_STEP];

   // sleep and clear-on-read controls
   assign readClearEn = stateReg.irqSleep[`LSR_BIT_READ_CLEAR];
   assign sleepEn     = stateReg.irqSleep[`LSR_BIT_SLEEP_IRQ];

   // interrupt enables and the two flags they gate
   assign satIrqEn = stateReg.irqEnable[`LSR_BIT_SAT_IEN];
   assign thrIrqEn = stateReg.irqEnable[`LSR_BIT_THR_IEN];  // see RULE_10
   assign satFlag  = stateReg.status[`LSR_BIT_SAT_FLAG];
   assign thrFlag  = stateReg.status[`LSR_BIT_THR_FLAG];

   // results only count while the oscillator runs
   assign resultValid    = evt.cycleDone && oscEnable;
   assign inRangeResult  = resultValid && !evt.outOfRange;
   assign outRangeResult = resultValid && evt.outOfRange;

   // persistence compare; a zero setting fires on every out-of-range result
   assign countInc = stateReg.persistCount + 4'h1;
   assign thrHit   = outRangeResult && (countInc >= evt.persistence);

   // autozero interval decode
   assign cycleTick     = evt.cycleStart && oscEnable;
   assign interval      = stateReg.autozero[6:0];
   assign intervalNever = (interval == `LSR_INTERVAL_NEVER);
   assign intervalFirst = (interval == `LSR_INTERVAL_FIRST);
   assign cycleInc      = stateReg.cycleCount + 7'h01;
   assign cycleWrap     = (cycleInc >= interval);
   assign azDue         = intervalFirst ? !stateReg.firstDone : (stateReg.cycleCount == 7'h00);

   // flag set events
   always_comb begin
      setMask = 8'h00;
      if (thrHit) begin
         setMask[`LSR_BIT_THR_FLAG] = 1'b1;  // see RULE_15
      end
      if (resultValid && evt.saturated) begin
         setMask[`LSR_BIT_SAT_FLAG] = 1'b1;
      end
      if (evt.calDone) begin
         setMask[`LSR_BIT_CAL_FLAG] = 1'b1;
      end
   end

   // flag clears: write one to clear, or clear on read
   always_comb begin
      clrMask = 8'h00;
      if (statusWrite) begin
         clrMask = regReq.wrData & STATUS_MASK;  // see RULE_14
      end
      if (statusRead && readClearEn) begin
         clrMask = STATUS_MASK;  // see RULE_04
      end
   end

   // per-bit flag update; set beats clear so an event in the clearing cycle is kept
   for (genvar b = 0; b < 8; b++) begin : g_flag
      assign statusNext[b] = STATUS_MASK[b] & ((stateReg.status[b] & ~clrMask[b]) | setMask[b]);
   end

   // a clear that leaves no flag standing ends sleep, as does dropping power-on or the sleep-after-interrupt bit
   assign clearedAll = (clrMask != 8'h00) && (statusNext == 8'h00);

   // next state
   always_comb begin
      stateNext = stateReg;

      // persistence counter, cleared on an in-range result or a hit; see RULE_15
      if (inRangeResult) begin
         stateNext.persistCount = 4'h0;
      end else if (thrHit) begin
         stateNext.persistCount = 4'h0;
      end else if (outRangeResult) begin
         stateNext.persistCount = countInc;
      end

      // the first-cycle autozero is spent until the next reset
      if (autozeroRun) begin
         stateNext.firstDone = 1'b1;
      end

      // cycle counter runs on cycle starts and wraps at the interval
      if (cycleTick) begin
         if (cycleWrap) begin
            stateNext.cycleCount = 7'h00;
         end else begin
            stateNext.cycleCount = cycleInc;
         end
      end

      // status flags
      stateNext.status = statusNext;

      // sleep; waking is tested first, since the interrupt still stands in the
      // cycle of its own clear and would otherwise send the device back to sleep
      if (!powerOnBit || !sleepEn) begin
         stateNext.sleeping = 1'b0;
      end else if (clearedAll) begin
         stateNext.sleeping = 1'b0;  // see RULE_08
      end else if (irqOut) begin
         stateNext.sleeping = 1'b1;  // see RULE_06
      end

      // register writes
      if (wrExtGain) begin
         stateNext.extGain = regReq.wrData;  // see RULE_02
      end
      if (wrIrqSleep) begin
         stateNext.irqSleep = regReq.wrData;
      end
      if (wrAutozero) begin
         stateNext.autozero = regReq.wrData;
      end
      if (wrIrqEnable) begin
         stateNext.irqEnable = regReq.wrData;  // see RULE_10
      end

      // read data, registered so it holds until the next read
      if (regReq.rdEn) begin
         stateNext.rdData = readMux(stateReg, regReq.addr);
      end
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stateReg.extGain      <= `LSR_RST_EXT_GAIN;
         stateReg.irqSleep     <= `LSR_RST_IRQ_SLEEP;
         stateReg.autozero     <= `LSR_RST_AUTOZERO;
         stateReg.irqEnable    <= `LSR_RST_IRQ_ENABLE;
         stateReg.status       <= 8'h00;
         stateReg.rdData       <= 8'h00;
         stateReg.persistCount <= 4'h0;
         stateReg.cycleCount   <= 7'h00;
         stateReg.firstDone    <= 1'b0;
         stateReg.sleeping     <= 1'b0;
      end else begin
         stateReg <= stateNext;
      end
   end

   // read data straight from its flip-flops
   assign regRdData = stateReg.rdData;

   // overall gain from the lower select and the two extension bits
   assign overallGain = decodeGain(gainSelect, topExtend, halfStep);  // see RULE_01

   // power-on still reads 1 elsewhere while sleeping; only the oscillator stops
   assign oscEnable = powerOnBit && !stateReg.sleeping;  // see RULE_05 / see RULE_07

   // interrupt from either enabled flag
   assign irqOut   = (thrFlag && thrIrqEn) || (satFlag && satIrqEn);  // see RULE_11
   assign irqPinOe = irqOut;  // open drain, drives low while asserted

   // 00h never; 7fh only before the first cycle after reset
   assign autozeroRun = cycleTick && !intervalNever && azDue;  // see RULE_09

endmodule

// ### test/lsr_regs_monitor.sv
/* port checker for the light sensor register bank.
   assumes a bind onto lsr_config_irq_regs, one clock domain. */
`timescale 1ns/1ps
module lsr_regs_monitor
   import lsr_pkg::*;
#(
   parameter logic [7:0] VIS_SCALE = 8'h00
) (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       reset,
   // register port
   input wire lsr_req_t   regReq,
   input wire logic [7:0] regRdData,
   // engine side
   input wire lsr_evt_t   evt,
   input wire logic       powerOnBit,
   input wire logic [1:0] gainSelect,
   // outputs
   input wire lsr_gain_t  overallGain,
   input wire logic       oscEnable,
   input wire logic       autozeroRun,
   input wire logic       irqOut,
   input wire logic       irqPinOe
);
   // one domain, so clock and reset are stated once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   property p_pin_oe; irqPinOe == irqOut; endproperty
   a_pin_oe: assert property (p_pin_oe) else $error("pin enable differs");
   property p_osc_off; !powerOnBit |-> !oscEnable; endproperty
   a_osc_off: assert property (p_osc_off) else $error("osc on at power off");
   property p_vis_rd; regReq.rdEn && regReq.addr == 8'he6 |=> regRdData == VIS_SCALE; endproperty
   a_vis_rd: assert property (p_vis_rd) else $error("scale byte wrong");
   property p_az; autozeroRun |-> evt.cycleStart; endproperty
   a_az: assert property (p_az) else $error("autozero off a cycle start");
   property p_irq_rise; $rose(irqOut) |-> $past(evt.cycleDone || regReq.wrEn); endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
   property p_irq_fall; $fell(irqOut) |-> $past(regReq.wrEn || regReq.rdEn); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without host");
   // sleep is entered only with the interrupt standing, and left with power-on held only after a host write or read
   property p_sleep; $fell(oscEnable) && powerOnBit && $past(powerOnBit) |-> irqOut; endproperty
   a_sleep: assert property (p_sleep) else $error("osc stopped without irq");
   property p_wake; $rose(oscEnable) && $past(powerOnBit) |-> $past(regReq.wrEn || regReq.rdEn); endproperty
   a_wake: assert property (p_wake) else $error("osc woke without clear");
   c_sleep: cover property (irqOut && !oscEnable && powerOnBit);
   c_az: cover property (autozeroRun);
   c_wake: cover property ($rose(oscEnable) && powerOnBit);
endmodule

// ### test/lsr_host_model.sv
/* register host model: single byte reads and writes on the strobe port.
   assumes the bench calls its tasks, one at a time. */
`timescale 1ns/1ps
module lsr_host_model
   import lsr_pkg::*;
(
   // clock
   input wire logic       clk_sys,
   // register port
   output lsr_req_t       regReq,
   input wire logic [7:0] regRdData
);
   initial regReq = '0;
   // one-cycle strobe; released fields show inverted values so stale data never matches
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge clk_sys) #1;
      regReq = '{wrEn: w, rdEn: !w, addr: a, wrData: d};
      @(posedge clk_sys) #1;
      q = regRdData;
      regReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
   endtask
   // single byte write to any offset; ones written to the status offset clear flags and wake a sleeping device once no flag is left standing
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      xfer(1'b0, a, 8'h00, q);
   endtask
endmodule

// ### test/tb_top.sv
/* bench top for the light sensor register bank.
   assumes host model and checker are compiled before it. */
`timescale 1ns/1ps
`include "lsr_cfg.svh"
module tb_top
   import lsr_pkg::*;
;
   localparam logic [7:0] VIS = 8'h94;  // arbitrary trim byte
   localparam logic [4:0] OOR = 5'h0c, INR = 5'h08, SAT = 5'h0a, CAL = 5'h01;
   logic       clk_sys = 1'b0, reset = 1'b1, powerOnBit = 1'b1, oscEnable, autozeroRun, irqOut, irqPinOe;
   logic [1:0] gainSelect = 2'h0;
   logic [7:0] regRdData, rd;
   lsr_req_t   regReq;
   lsr_evt_t   evt = {5'h00, 4'h2};
   lsr_gain_t  overallGain;
   int         errors = 0, n_compared = 0;
   lsr_config_irq_regs #(.VIS_SCALE(VIS)) i_dut (.clk_sys, .reset, .regReq, .regRdData, .evt, .powerOnBit,
      .gainSelect, .overallGain, .oscEnable, .autozeroRun, .irqOut, .irqPinOe);
   lsr_host_model i_host (.clk_sys, .regReq, .regRdData);
   // clock and watchdog, the run needs about 120 cycles
   initial forever #50 clk_sys = ~clk_sys;
   initial begin
      #500_000;
      errors++;
      tally_and_finish();
   end
   task automatic chk8(input logic [7:0] g, e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // one engine event for a single cycle, persistence kept at 2
   task automatic ev(input logic [4:0] b);
      @(posedge clk_sys) #1 evt = {b, 4'h2};
      @(posedge clk_sys) #1 evt = {5'h00, 4'h2};
   endtask
   task automatic do_reset();
      reset = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1 reset = 1'b0;
   endtask
   task automatic t_reset_vals();
      logic [7:0] a[6] = '{8'h9f, 8'hab, 8'hd6, 8'hdd, 8'he6, 8'h50};
      logic [7:0] e[6] = '{8'h04, 8'h4c, 8'h7f, 8'h00, VIS, 8'h00};
      i_host.wr(`LSR_ADDR_VIS_SCALE, ~VIS);
      foreach (a[i]) begin
         i_host.rd(a[i], rd);
         chk8(rd, e[i]);
      end
      // host scales a visible result of 100 by the signed percentage in the trim byte
      i_host.rd(`LSR_ADDR_VIS_SCALE, rd);
      chk8(rd[7] ? 8'h64 - {1'b0, rd[6:0]} : 8'h64 + {1'b0, rd[6:0]}, 8'h50);
   endtask
   task automatic t_gain();
      logic [3:0] c[6] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'hd, 4'hf};
      lsr_gain_t  g[6] = '{GAIN_HALF, GAIN_X1, GAIN_X4, GAIN_X16, GAIN_X64, GAIN_X128};
      foreach (c[i]) begin
         gainSelect = c[i][3:2];
         i_host.wr(`LSR_ADDR_EXT_GAIN, {3'h0, c[i][1], 1'b0, c[i][0], 2'h0});
         chk8({5'h00, overallGain}, {5'h00, g[i]});
      end
      i_host.rd(`LSR_ADDR_EXT_GAIN, rd);
      chk8(rd, 8'h14);
   endtask
   task automatic t_irq();
      i_host.wr(`LSR_ADDR_IRQ_ENABLE, 8'h10);
      ev(OOR);
      ev(INR);
      ev(OOR);
      chk8({7'h00, irqOut}, 8'h00);
      ev(OOR);
      chk8({7'h00, irqOut}, 8'h01);
      i_host.wr(`LSR_ADDR_IRQ_ENABLE, 8'h80);
      chk8({7'h00, irqOut}, 8'h00);
      ev(SAT);
      chk8({7'h00, irqOut}, 8'h01);
      i_host.wr(`LSR_ADDR_STATUS, 8'h90);
      i_host.rd(`LSR_ADDR_STATUS, rd);
      chk8(rd, 8'h00);
   endtask
   task automatic t_sleep();
      i_host.wr(`LSR_ADDR_IRQ_SLEEP, 8'h5c);
      powerOnBit = 1'b0;
      @(posedge clk_sys) #1 chk8({7'h00, oscEnable}, 8'h00);
      powerOnBit = 1'b1;
      @(posedge clk_sys) #1 chk8({7'h00, oscEnable}, 8'h01);
      i_host.wr(`LSR_ADDR_IRQ_ENABLE, 8'h10);
      ev(OOR);
      ev(OOR);
      for (int i = 0; i < 10 && oscEnable; i++) @(posedge clk_sys);
      i_host.rd(`LSR_ADDR_STATUS, rd);
      chk8({rd[7:1], oscEnable}, 8'h10);
      i_host.wr(`LSR_ADDR_STATUS, 8'h10);
      chk8({6'h00, oscEnable, irqOut}, 8'h02);
      i_host.wr(`LSR_ADDR_IRQ_SLEEP, 8'hcc);
      ev(CAL);
      ev(OOR);
      ev(OOR);
      i_host.rd(`LSR_ADDR_STATUS, rd);
      chk8(rd, 8'h18);
      i_host.rd(`LSR_ADDR_STATUS, rd);
      chk8(rd, 8'h00);
   endtask
   // autozero pattern over cycle starts, pat bit 0 is the first cycle
   task automatic t_az(input logic [7:0] n, input int cnt, input logic [5:0] pat);
      i_host.wr(`LSR_ADDR_AUTOZERO, n);
      for (int i = 0; i < cnt; i++) begin
         @(posedge clk_sys) #1 evt = {5'h10, 4'h2};
         #1 chk8({7'h00, autozeroRun}, {7'h00, pat[i]});
         @(posedge clk_sys) #1 evt = {5'h00, 4'h2};
      end
   endtask
   task automatic tally_and_finish();
      if (errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence; the second reset re-arms the first-cycle autozero
   initial begin
      do_reset();
      t_reset_vals();
      t_gain();
      t_irq();
      t_sleep();
      t_az(8'h03, 6, 6'b001001);
      t_az(8'h00, 3, 6'b000000);
      do_reset();
      t_az(8'h7f, 3, 6'b000001);
      tally_and_finish();
   end
endmodule
bind lsr_config_irq_regs lsr_regs_monitor #(.VIS_SCALE(VIS_SCALE)) i_mon (.clk_sys, .reset, .regReq, .regRdData,
   .evt, .powerOnBit, .gainSelect, .overallGain, .oscEnable, .autozeroRun, .irqOut, .irqPinOe);
